// File: bfq_bridge_model.sv
// bridge and comparator model: bootstrap caps, vds comparators, off-state load sense
// assumes gate drives from the block under test and fault requests from the bench
module bfq_bridge_model
    import bfq_pkg::*;
(
    // clock and reset
    input  wire logic     clk_in,
    input  wire logic     rst_b_in,
    // gate drives seen at the bridge
    input  wire logic [3:0] gate_drive_in,
    // fault requests from the bench
    input  wire logic [3:0] vds_inj_in,
    input  wire logic [1:0] bs_fail_in,
    input  wire logic [1:0] bs_drop_in,
    input  wire logic       ol_open_in,
    // comparator levels
    output bfq_cmp_t        cmp_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] chg_ff;
    logic [1:0] cnt_ff [2];
    // a cap only recharges while its low side conducts, and a failed cap never does
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            chg_ff    <= 2'h3;
            cnt_ff[0] <= 2'h0;
            cnt_ff[1] <= 2'h0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (bs_drop_in[p] || bs_fail_in[p]) begin
                    chg_ff[p] <= 1'b0;
                    cnt_ff[p] <= 2'h0;
                end else if (gate_drive_in[2*p]) begin
                    if (cnt_ff[p] == 2'h2) chg_ff[p] <= 1'b1;
                    else cnt_ff[p] <= cnt_ff[p] + 2'h1;
                end else begin
                    cnt_ff[p] <= 2'h0;
                end
            end
        end
    end
    // an off switch stands the full rail, so its comparator reads abnormal
    assign cmp_out.vds_over   = vds_inj_in | ~gate_drive_in;
    assign cmp_out.bs_low_on  = ~chg_ff;
    assign cmp_out.bs_low_off = ~chg_ff;
    assign cmp_out.ol_over    = ol_open_in & (gate_drive_in == 4'h0);
endmodule // bfq_bridge_model

// File: bfq_core.sv
// fault qualification and gate disable for a full bridge with apb registers
// assumes comparator and gate command inputs synchronous to clk_in
// How it works
// - leaving all-off before open-load timeout clears the timer, no open load
// - open-load fault flag drops on load recovery or off-state exit; bit stays
// - test current select picks 10k or 2.5k open-load threshold
// - bootstrap manager enabled at reset, disabled by writing disable bit 1
// - managed high-side turn-on waits for bootstrap, driving low-side to recharge
// - bootstrap drop below turn-off limit during high-side on starts recharge
// - recharge not done within 200 us ends cycle, fault valid
// - manager disabled: undervoltage during high-side on is valid at once
// - stop-on-fault 0: latch, flag, bit, disable that switch; cleared by reset or turn-on
// - bootstrap diag bit cleared only by reading its register or power-on
// - stop-on-fault 1: bootstrap fault disables all; only resets clear
// - bootstrap mask bit disables bootstrap monitoring entirely
// - separate 6-bit high and low vds threshold codes, 50 mV steps
// - vds qualify time is 6-bit code times 100 ns
// - mode bit selects debounce (default) or blanking
// - debounce: time fault while switch on, reset on normal, validate on timeout
// - blanking: ignore comparator after turn-on until timer ends
// - stop-on-fault 0: vds fault disables that switch; reset, read, turn-on clear
// - vds diag bits cleared only by reading their register or power-on
// - stop-on-fault 1: vds fault disables all; read or reset clears
// - low-side fault sets low bit, high-side sets high bit, disables switch
//
// Design decisions made here: register access over APB and the register addresses.
module bfq_core
    import bfq_pkg::*;
#(
    parameter int OL_TIMEOUT = OL_TIMEOUT_CYC,
    parameter int BS_TIMEOUT = BS_TIMEOUT_CYC
)
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // bridge side
    input  wire logic        fault_reset_input_n_in,
    input  wire logic [3:0]  gate_cmd_in,
    input  wire bfq_cmp_t    cmp_in,
    output logic      [3:0]  gate_drive_out,
    output logic      [5:0]  high_side_vds_threshold_out,
    output logic      [5:0]  low_side_vds_threshold_out,
    output logic             load_test_current_select_out,
    output logic             fault_flag_out
);
    // configuration registers
    logic [3:0]  cfg_ff;
    logic [5:0]  vth_ff;
    logic [5:0]  vtl_ff;
    logic [5:0]  tvd_ff;
    logic        mask_bs_ff;
    logic [3:0]  vds_diag_ff;
    logic [1:0]  bs_diag_ff;
    logic        open_load_flag_ff;
    logic        ol_active_ff;
    logic [31:0] ol_cnt_ff;
    logic [3:0]  vds_latch_ff;
    logic [1:0]  bs_latch_ff;

    logic        all_off_ff;
    logic [3:0]  cmd_q_ff;
    logic [31:0] prdata_ff;
    logic [3:0]  vds_valid;
    logic [1:0]  bs_valid;

    // bus decode
    logic        rd_vds;
    logic        rd_bs;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        rstpin_low;
    logic [3:0]  turn_on;
    logic        all_off_cmd;

    wire stop_on_fault_enable = cfg_ff[CFG_ESF_BIT];
    wire bootstrap_manager_disable = cfg_ff[CFG_DBM_BIT];
    wire vds_qualifier_mode = cfg_ff[CFG_VDQ_BIT];

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == ADDR_CONFIG) || (a == ADDR_VDS_CFG) || (a == ADDR_MASK) ||
                   (a == ADDR_DIAG_VDS) || (a == ADDR_DIAG_BS) || (a == ADDR_STATE);
    endfunction

    // apb: zero wait state, error on unmapped addresses
    assign addr_ok     = addr_hit(paddr_in);
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;
    assign wr_en  = psel_in && penable_in && pwrite_in && addr_ok;
    assign rd_en  = psel_in && penable_in && !pwrite_in;
    assign rd_vds = rd_en && (paddr_in == ADDR_DIAG_VDS);
    assign rd_bs  = rd_en && (paddr_in == ADDR_DIAG_BS);
    assign prdata_out = prdata_ff;
    assign rstpin_low = !fault_reset_input_n_in;
    assign turn_on = gate_cmd_in & ~cmd_q_ff;
    assign all_off_cmd = (gate_cmd_in == 4'h0);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_ff     <= CONFIG_RST[3:0];  // manager enabled, debounce default
            vth_ff     <= VTH_RST;
            vtl_ff     <= VTL_RST;
            tvd_ff     <= TVD_RST;
            mask_bs_ff <= 1'b0;
        end else if (wr_en) begin
            if (paddr_in == ADDR_CONFIG) begin
                cfg_ff <= pwdata_in[3:0];
            end else if (paddr_in == ADDR_VDS_CFG) begin
                vth_ff <= pwdata_in[VDS_TH_LSB +: 6];
                vtl_ff <= pwdata_in[VDS_TL_LSB +: 6];
                tvd_ff <= pwdata_in[VDS_TVD_LSB +: 6];
            end else if (paddr_in == ADDR_MASK) begin
                mask_bs_ff <= pwdata_in[MASK_BS_BIT];
            end
        end
    end

    // read data is registered and presented in the access phase edge after setup
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            if (paddr_in == ADDR_CONFIG) begin
                prdata_ff <= {28'h0, cfg_ff};
            end else if (paddr_in == ADDR_VDS_CFG) begin
                prdata_ff <= {10'h0, tvd_ff, 2'h0, vtl_ff, 2'h0, vth_ff};
            end else if (paddr_in == ADDR_MASK) begin
                prdata_ff <= {31'h0, mask_bs_ff};
            end else if (paddr_in == ADDR_DIAG_VDS) begin
                prdata_ff <= {28'h0, vds_diag_ff};
            end else if (paddr_in == ADDR_DIAG_BS) begin
                prdata_ff <= {27'h0, open_load_flag_ff, 2'h0, bs_diag_ff};
            end else if (paddr_in == ADDR_STATE) begin
                prdata_ff <= {25'h0, fault_flag_out, bs_latch_ff, vds_latch_ff};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    assign high_side_vds_threshold_out  = vth_ff;
    assign low_side_vds_threshold_out   = vtl_ff;
    assign load_test_current_select_out = cfg_ff[CFG_OLI_BIT];  // selects analog test current

    // off-state open-load timer
    // any step out of all-off restarts it, so a pwm pattern with off-times under the timeout never reports open load
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ol_cnt_ff    <= 32'h0;
            ol_active_ff <= 1'b0;
            all_off_ff   <= 1'b0;
        end else begin
            all_off_ff <= (gate_drive_out == 4'h0);
            if (!all_off_ff || !cmp_in.ol_over) begin
                ol_cnt_ff    <= 32'h0;
                ol_active_ff <= 1'b0;
            end else if (ol_cnt_ff >= 32'(OL_TIMEOUT - 1)) begin
                ol_active_ff <= 1'b1;
            end else begin
                ol_cnt_ff <= ol_cnt_ff + 32'h1;
            end
        end
    end

    // open-load diag bit: set wins over the read clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            open_load_flag_ff <= 1'b0;
        end else if (ol_active_ff) begin
            open_load_flag_ff <= 1'b1;
        end else if (rd_bs) begin
            open_load_flag_ff <= 1'b0;
        end
    end

    // vds qualifiers, one per switch
    // blanking starts on the command edge; a drive released after a read gets no new window
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_vds
            logic [11:0] tmr_ff;
            logic        blank_ff;
            wire  [11:0] limit = 12'(tvd_ff) * 12'(VDQ_STEP_CYC);
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    tmr_ff   <= 12'h0;
                    blank_ff <= 1'b0;
                end else if (!vds_qualifier_mode) begin
                    blank_ff <= 1'b0;
                    if (gate_drive_out[g] && cmp_in.vds_over[g] && tmr_ff < limit) begin
                        tmr_ff <= tmr_ff + 12'h1;
                    end else if (!(gate_drive_out[g] && cmp_in.vds_over[g])) begin
                        tmr_ff <= 12'h0;
                    end
                end else if (turn_on[g]) begin
                    tmr_ff   <= 12'h0;
                    blank_ff <= (limit != 12'h0);
                end else if (blank_ff) begin
                    tmr_ff   <= tmr_ff + 12'h1;
                    blank_ff <= (tmr_ff + 12'h1 < limit);
                end
            end
            assign vds_valid[g] = gate_drive_out[g] && cmp_in.vds_over[g] &&
                                  (vds_qualifier_mode ? !blank_ff : (tmr_ff >= limit));
        end
    endgenerate

    // bootstrap managers, one per phase; high side index 2p+1, low side 2p
    // disable or mask parks the manager in idle so it never holds a high side off
    generate
        for (g = 0; g < 2; g++) begin : g_bs
            bfq_bs_state_t st_ff;
            logic [15:0]   cnt_ff;
            logic          timeout;
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    st_ff  <= BS_IDLE;
                    cnt_ff <= 16'h0;
                end else if (bootstrap_manager_disable || mask_bs_ff || !gate_cmd_in[2*g+1] || bs_latch_ff[g]) begin
                    st_ff  <= BS_IDLE;
                    cnt_ff <= 16'h0;
                end else begin
                    case (st_ff)
                        BS_IDLE: begin
                            cnt_ff <= 16'h0;
                            st_ff  <= cmp_in.bs_low_on[g] ? BS_CHARGE : BS_RUN;
                        end
                        BS_CHARGE: begin
                            cnt_ff <= cnt_ff + 16'h1;
                            if (!cmp_in.bs_low_on[g]) begin
                                st_ff <= BS_RUN;
                            end
                        end
                        BS_RUN: begin
                            cnt_ff <= 16'h0;
                            if (cmp_in.bs_low_off[g]) begin
                                st_ff <= BS_CHARGE;
                            end
                        end
                        default: st_ff <= BS_IDLE;
                    endcase
                end
            end
            assign timeout = (st_ff == BS_CHARGE) && (cnt_ff >= 16'(BS_TIMEOUT - 1));
            assign bs_valid[g] = !mask_bs_ff && (bootstrap_manager_disable ?
                (gate_cmd_in[2*g+1] && cmp_in.bs_low_off[g]) : timeout);
        end
    endgenerate

    // latched fault states
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vds_latch_ff <= 4'h0;
            bs_latch_ff  <= 2'h0;
            cmd_q_ff     <= 4'h0;
        end else begin
            cmd_q_ff <= gate_cmd_in;
            for (int i = 0; i < 4; i++) begin
                if (vds_valid[i]) begin
                    vds_latch_ff[i] <= 1'b1;
                end else if (rstpin_low || rd_vds || (!stop_on_fault_enable && turn_on[i])) begin
                    vds_latch_ff[i] <= 1'b0;
                end
            end
            for (int p = 0; p < 2; p++) begin
                if (bs_valid[p]) begin
                    bs_latch_ff[p] <= 1'b1;
                end else if (rstpin_low || (!stop_on_fault_enable && turn_on[2*p+1])) begin
                    bs_latch_ff[p] <= 1'b0;
                end
            end
        end
    end

    // diag bits: only a read or power-on clears, set wins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vds_diag_ff <= 4'h0;
            bs_diag_ff  <= 2'h0;
        end else begin
            vds_diag_ff <= vds_valid | (rd_vds ? 4'h0 : vds_diag_ff);
            bs_diag_ff  <= bs_valid | (rd_bs ? 2'h0 : bs_diag_ff);
        end
    end

    // gate drive: charge cycle forces the low side, faults gate off
    // stop-on-fault widens any single kill to the whole bridge
    logic [3:0] kill;
    logic [3:0] drive;
    always_comb begin
        kill  = vds_latch_ff | {bs_latch_ff[1], 1'b0, bs_latch_ff[0], 1'b0};
        drive = gate_cmd_in;
        if (g_bs[0].st_ff != BS_RUN && !bootstrap_manager_disable && !mask_bs_ff && gate_cmd_in[SW_AH]) begin
            drive[SW_AH] = 1'b0;
            drive[SW_AL] = (g_bs[0].st_ff == BS_CHARGE);
        end
        if (g_bs[1].st_ff != BS_RUN && !bootstrap_manager_disable && !mask_bs_ff && gate_cmd_in[SW_BH]) begin
            drive[SW_BH] = 1'b0;
            drive[SW_BL] = (g_bs[1].st_ff == BS_CHARGE);
        end
        if (stop_on_fault_enable && (kill != 4'h0)) begin
            kill = 4'hf;
        end
    end

    // drives and flag are registered, so both lag the latches by one edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gate_drive_out <= 4'h0;
            fault_flag_out <= 1'b0;
        end else begin
            gate_drive_out <= drive & ~kill;
            fault_flag_out <= (vds_latch_ff != 4'h0) || (bs_latch_ff != 2'h0) || ol_active_ff;
        end
    end

    // checks on the fault paths
    chk_ol_clear_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !all_off_ff |=> !ol_active_ff) else $error("open load active outside off-state");

    chk_ol_bit_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ol_active_ff |=> open_load_flag_ff) else $error("open-load bit not set");

    chk_vds_diag_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (vds_diag_ff != 4'h0) && !rd_vds |=> ($past(vds_diag_ff) & ~vds_diag_ff) == 4'h0)
        else $error("vds diag bit lost without read");

    chk_bs_diag_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !rd_bs |=> ($past(bs_diag_ff) & ~bs_diag_ff) == 2'h0)
        else $error("bootstrap diag bit lost without read");

    chk_esf_all_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        stop_on_fault_enable && (vds_latch_ff != 4'h0) |=> gate_drive_out == 4'h0)
        else $error("stop-on-fault did not disable all switches");

    chk_bs_esf_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        stop_on_fault_enable && (bs_latch_ff != 2'h0) |=> gate_drive_out == 4'h0)
        else $error("bootstrap stop-on-fault did not disable all switches");

    chk_vds_kill_one: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        vds_latch_ff[SW_AL] |=> !gate_drive_out[SW_AL]) else $error("faulted switch still driven");

    chk_mask_no_bs: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        mask_bs_ff |-> bs_valid == 2'h0) else $error("masked bootstrap fault reported");

    chk_bs_latch_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        bs_valid != 2'h0 |=> ##1 fault_flag_out) else $error("bootstrap fault did not raise flag");

    chk_pin_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        rstpin_low && (vds_valid == 4'h0) && (bs_valid == 2'h0) |=> (vds_latch_ff == 4'h0) && (bs_latch_ff == 2'h0))
        else $error("reset pin did not clear fault states");

    chk_hs_held: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (g_bs[0].st_ff == BS_CHARGE) && !bootstrap_manager_disable && !mask_bs_ff |=> !gate_drive_out[SW_AH])
        else $error("high side driven during recharge");

    chk_vds_set_diag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        vds_valid[SW_AH] |=> vds_diag_ff[SW_AH]) else $error("vds fault bit not set");

    chk_dbm_instant: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        bootstrap_manager_disable && !mask_bs_ff && gate_cmd_in[SW_BH] && cmp_in.bs_low_off[1] |=> bs_latch_ff[1])
        else $error("unmanaged bootstrap fault not immediate");
endmodule // bfq_core

// File: bfq_core_tb.sv
// self-checking bench for bfq_core with apb master tasks and the bridge model
// assumes short open-load and bootstrap timeouts set through the parameters
module bfq_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bfq_pkg::*;
    logic clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr, frst_n, ltcs, flag, ol_open;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  gate_cmd, gate_drive, vds_inj;
    logic [1:0]  bs_fail, bs_drop;
    logic [5:0]  vth, vtl;
    bfq_cmp_t    cmp;
    int          error_cnt = 0;
    int          cmp_count = 0;
    bfq_core #(.OL_TIMEOUT(20), .BS_TIMEOUT(16)) dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .fault_reset_input_n_in(frst_n),
        .gate_cmd_in(gate_cmd), .cmp_in(cmp), .gate_drive_out(gate_drive),
        .high_side_vds_threshold_out(vth), .low_side_vds_threshold_out(vtl),
        .load_test_current_select_out(ltcs), .fault_flag_out(flag));
    bfq_bridge_model model (.clk_in(clk_in), .rst_b_in(rst_b_in), .gate_drive_in(gate_drive),
        .vds_inj_in(vds_inj), .bs_fail_in(bs_fail), .bs_drop_in(bs_drop), .ol_open_in(ol_open),
        .cmp_out(cmp));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_in);
        end
        if (n >= 50) chk(1'b0, 1'b1, "apb hang");
        rd = prdata;
        chk(pslverr, (a > ADDR_STATE) ? 1'b1 : 1'b0, "pslverr");
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask
    task automatic t_regs;
        apb(1'b0, ADDR_CONFIG, 32'h0); chk(rd, 32'h0, "config reset");
        apb(1'b0, ADDR_VDS_CFG, 32'h0); chk(rd, 32'h001f1010, "vds cfg reset");
        apb(1'b1, ADDR_VDS_CFG, 32'h0004152a);
        wt(2); chk(vth, 6'h2a, "high thr"); chk(vtl, 6'h15, "low thr");
        apb(1'b1, ADDR_CONFIG, 32'h1); wt(2); chk(ltcs, 1'b1, "test current");
        apb(1'b1, ADDR_CONFIG, 32'h0); wt(2); chk(ltcs, 1'b0, "test current off");
        apb(1'b0, 8'h20, 32'h0); chk(rd, 32'h0, "unmapped read");
    endtask
    task automatic t_debounce;
        @(posedge clk_in) gate_cmd <= 4'b0101;
        wt(3); vds_inj <= 4'b0001; wt(2); vds_inj <= 4'b0000; wt(10);
        chk(gate_drive, 4'b0101, "glitch ignored");
        vds_inj <= 4'b0001; wt(2); chk(gate_drive, 4'b0101, "still qualifying");
        wt(8); chk(gate_drive, 4'b0100, "low side a off only");
        chk(flag, 1'b1, "flag on vds"); vds_inj <= 4'b0000;
        apb(1'b0, ADDR_DIAG_VDS, 32'h0); chk(rd[3:0], 4'b0001, "a low bit");
        wt(3); chk(flag, 1'b0, "read clears flag");
        apb(1'b0, ADDR_DIAG_VDS, 32'h0); chk(rd[3:0], 4'b0000, "bit cleared");
        vds_inj <= 4'b0100; wt(12); chk(gate_drive, 4'b0001, "b low off");
        vds_inj <= 4'b0000; gate_cmd <= 4'b0000; wt(2);
        @(posedge clk_in) gate_cmd <= 4'b0100;
        wt(3); chk(gate_drive, 4'b0100, "turn-on clears"); chk(flag, 1'b0, "flag turn-on");
        apb(1'b0, ADDR_DIAG_VDS, 32'h0); chk(rd[3:0], 4'b0100, "b low bit");
        gate_cmd <= 4'b0000;
    endtask
    task automatic t_blank_esf;
        apb(1'b1, ADDR_CONFIG, 32'hc);
        vds_inj <= 4'b0010; gate_cmd <= 4'b0110;
        wt(3); chk(gate_drive, 4'b0110, "blanked");
        wt(10); chk(gate_drive, 4'b0000, "all off"); chk(flag, 1'b1, "flag esf");
        apb(1'b0, ADDR_STATE, 32'h0); chk(rd, 32'h42, "state view");
        vds_inj <= 4'b0000;
        apb(1'b0, ADDR_DIAG_VDS, 32'h0); chk(rd[3:0], 4'b0010, "a high bit");
        wt(3); chk(gate_drive, 4'b0110, "read releases"); chk(flag, 1'b0, "flag read");
        gate_cmd <= 4'b0000;
    endtask
    task automatic t_boot;
        int n;
        apb(1'b1, ADDR_CONFIG, 32'h0);
        bs_fail <= 2'b01; gate_cmd <= 4'b0010;
        wt(3); chk(gate_drive, 4'b0001, "recharge first");
        wt(22); chk(gate_drive[1], 1'b0, "high side held"); chk(flag, 1'b1, "bs timeout");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[1:0], 2'b01, "bs bit a");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[1:0], 2'b00, "bs bit read clear");
        bs_fail <= 2'b00; gate_cmd <= 4'b0000; wt(2);
        @(posedge clk_in) gate_cmd <= 4'b0010;
        wt(12); chk(gate_drive, 4'b0010, "high side after charge"); chk(flag, 1'b0, "turn-on clears");
        bs_drop <= 2'b01; wt(1); bs_drop <= 2'b00;
        n = 0;
        while (gate_drive[0] !== 1'b1 && n < 10) begin
            n++;
            wt(1);
        end
        chk(gate_drive[0], 1'b1, "recharge on drop");
        wt(12); chk(gate_drive, 4'b0010, "recharge done");
        gate_cmd <= 4'b0000;
    endtask
    task automatic t_boot_nomgr;
        apb(1'b1, ADDR_CONFIG, 32'h6);
        gate_cmd <= 4'b1000; wt(3);
        bs_drop <= 2'b10; wt(1); bs_drop <= 2'b00;
        wt(3); chk(gate_drive, 4'b0000, "immediate all off"); chk(flag, 1'b1, "flag");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[1:0], 2'b10, "bs bit b");
        chk(flag, 1'b1, "read keeps state"); gate_cmd <= 4'b0000;
        frst_n <= 1'b0; wt(2); frst_n <= 1'b1; wt(3);
        chk(flag, 1'b0, "reset pin clears");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[1:0], 2'b10, "reset pin keeps bit");
        apb(1'b1, ADDR_MASK, 32'h1); apb(1'b1, ADDR_CONFIG, 32'h2);
        gate_cmd <= 4'b1000; wt(2);
        bs_drop <= 2'b10; wt(6); bs_drop <= 2'b00;
        chk(gate_drive, 4'b1000, "masked"); chk(flag, 1'b0, "masked flag");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[1:0], 2'b00, "masked bit");
        gate_cmd <= 4'b0000; apb(1'b1, ADDR_MASK, 32'h0);
    endtask
    task automatic t_open_load;
        ol_open <= 1'b1; wt(12);
        gate_cmd <= 4'b0001; wt(3); gate_cmd <= 4'b0000; wt(12);
        chk(flag, 1'b0, "timer restarted");
        gate_cmd <= 4'b0001; wt(3); gate_cmd <= 4'b0000;
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[DIAG_OL_BIT], 1'b0, "no open load");
        wt(30); chk(flag, 1'b1, "open load flag");
        ol_open <= 1'b0; wt(3); chk(flag, 1'b0, "flag drops");
        apb(1'b0, ADDR_DIAG_BS, 32'h0); chk(rd[DIAG_OL_BIT], 1'b1, "bit stays");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst_b_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; frst_n = 1'b1; gate_cmd = 4'h0; vds_inj = 4'h0;
        bs_fail = 2'h0; bs_drop = 2'h0; ol_open = 1'b0;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_debounce();
        t_blank_esf();
        t_boot();
        t_boot_nomgr();
        t_open_load();
        tally_and_finish();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(100 * 5000);
        error_cnt++;
        tally_and_finish();
    end
endmodule // bfq_core_tb

// File: bfq_pkg.sv
// package for the bridge fault qualifier: register map, field layout, timing counts
// assumes a 10 MHz core clock and a 32-bit apb register bus
package bfq_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] ADDR_VDS_CFG  = 8'h04;
    localparam logic [7:0] ADDR_MASK     = 8'h08;
    localparam logic [7:0] ADDR_DIAG_VDS = 8'h0c;
    localparam logic [7:0] ADDR_DIAG_BS  = 8'h10;
    localparam logic [7:0] ADDR_STATE    = 8'h14;
    // config field positions
    localparam int CFG_OLI_BIT  = 0;
    localparam int CFG_DBM_BIT  = 1;
    localparam int CFG_ESF_BIT  = 2;
    localparam int CFG_VDQ_BIT  = 3;
    localparam int VDS_TH_LSB   = 0;
    localparam int VDS_TL_LSB   = 8;
    localparam int VDS_TVD_LSB  = 16;
    localparam int MASK_BS_BIT  = 0;
    // diag bit positions
    localparam int DIAG_OL_BIT  = 4;
    // reset values
    localparam logic [31:0] CONFIG_RST  = 32'h0000_0000;
    localparam logic [5:0]  VTH_RST     = 6'h10;
    localparam logic [5:0]  VTL_RST     = 6'h10;
    localparam logic [5:0]  TVD_RST     = 6'h1f;
    // timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int VDQ_STEP_NS     = 100;
    localparam int VDQ_STEP_CYC    = (VDQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BS_TIMEOUT_US   = 200;
    localparam int BS_TIMEOUT_CYC  = (BS_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int OL_TIMEOUT_MS   = 100;
    localparam int OL_TIMEOUT_CYC  = (OL_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
    // switch order in every 4-bit vector: a_low, a_high, b_low, b_high
    localparam int SW_AL = 0;
    localparam int SW_AH = 1;
    localparam int SW_BL = 2;
    localparam int SW_BH = 3;
    typedef struct packed {
        logic [3:0] vds_over;   // vds comparators
        logic [1:0] bs_low_on;  // bootstrap below turn-on limit, per phase
        logic [1:0] bs_low_off; // bootstrap below turn-off limit (uv), per phase
        logic       ol_over;    // off-state load voltage above threshold
    } bfq_cmp_t;
    typedef enum logic [2:0] {
        BS_IDLE   = 3'b001,
        BS_CHARGE = 3'b010,
        BS_RUN    = 3'b100
    } bfq_bs_state_t;
endpackage : bfq_pkg
